// ==== shared/iod_pkg.sv ====
package iod_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned IOD_OP_W = 16;
    localparam int unsigned IOD_PTR_W = 12;
    localparam int unsigned IOD_BANK_W = 4;
    localparam int unsigned IOD_FILE_W = 8;
    localparam int unsigned IOD_LIT_W = 6;
    localparam int unsigned IOD_PC_W = 21;

    // ------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------
    localparam logic [7:0] IOD_SUB_FAMILY = 8'he9;   // 1110 1001 ffkk kkkk
    localparam logic [1:0] IOD_SEL_FRAME = 2'h3;     // Select 11: frame and return
    localparam int unsigned IOD_SEL_LSB = 6;
    localparam int unsigned IOD_ACCESS_BIT = 8;
    localparam int unsigned IOD_DEST_BIT = 9;
    localparam logic [7:0] IOD_OFFSET_MAX = 8'h5f;   // Highest offset operand
    localparam logic [7:0] IOD_ACCESS_SPLIT = 8'h60; // Access bank low/high split
    localparam logic [3:0] IOD_ACCESS_HIGH_BANK = 4'hf;
    localparam logic [3:0] IOD_ACCESS_LOW_BANK = 4'h0;

    // ------------------------------------------------------------
    // Reset values and states
    // ------------------------------------------------------------
    localparam logic [IOD_PTR_W-1:0] IOD_PTR_RESET = 12'h000;

    typedef enum logic [0:0] {
        IOD_EXEC,
        IOD_RET_NOP
    } iod_state_t;
endpackage : iod_pkg

// ==== src/iod_addr_gen.sv ====
`timescale 1ns/1ps
// Effective file address for operands that carry the access-select bit
module iod_addr_gen (
    input wire logic i_ext_enable,
    input wire logic i_access_sel,
    input wire logic [iod_pkg::IOD_FILE_W-1:0] i_file,
    input wire logic [iod_pkg::IOD_BANK_W-1:0] i_bank_select,
    input wire logic [iod_pkg::IOD_PTR_W-1:0] i_frame_ptr,
    output logic [iod_pkg::IOD_PTR_W-1:0] o_addr,
    output logic o_indexed
);
    import iod_pkg::*;

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    // Offset mode needs extension on, access bit 0, operand up to 5Fh
    wire use_offset = i_ext_enable && !i_access_sel
                      && (i_file <= IOD_OFFSET_MAX);
    wire [IOD_PTR_W-1:0] offset_addr = i_frame_ptr + {4'h0, i_file};
    // Access bank: low part from bank 0, high part from the top bank
    wire [IOD_BANK_W-1:0] access_bank = (i_file < IOD_ACCESS_SPLIT) ? IOD_ACCESS_LOW_BANK
                                                                     : IOD_ACCESS_HIGH_BANK;
    wire [IOD_PTR_W-1:0] literal_addr = i_access_sel ? {i_bank_select, i_file}
                                                     : {access_bank, i_file};

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_addr = use_offset ? offset_addr : literal_addr;
    assign o_indexed = use_offset;
endmodule : iod_addr_gen

// ==== src/iod_decode.sv ====
`timescale 1ns/1ps
// Functional notes
// - Pointer subtract takes a 6-bit literal from pointer 0, 1 or 2; one cycle, no flags.
// - Select 11 subtracts the literal from the frame pointer and returns to the stack top.
// - Subtract-and-return takes two cycles, the second a no-operation, flags untouched.
// - Extension off: a=0 addresses the access bank, a=1 the bank named by the bank register.
// - The extension enable alone turns on indexed offset addressing, with no other control.
// - Extension on and a=0, an operand up to 5Fh is added as offset to the frame pointer.
// - Operands above 5Fh keep literal addressing even with the extension on.
// - The offset rule covers every byte- and bit-oriented instruction with the access bit.
// - Destination bit keeps its meaning: 0 to working register, 1 back to the operand.
// - A configuration bit at 1 enables offset addressing; the pointer subtracts decode whatever its value.
module iod_decode #(
    parameter int unsigned PTR_W = iod_pkg::IOD_PTR_W,
    parameter int unsigned PC_W = iod_pkg::IOD_PC_W
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_ext_enable_cfg,
    input wire logic i_instr_valid,
    input wire logic [iod_pkg::IOD_OP_W-1:0] i_opcode,
    input wire logic [iod_pkg::IOD_BANK_W-1:0] i_bank_select,
    input wire logic [PC_W-1:0] i_top_of_return_stack,
    input wire logic i_ptr_load,
    input wire logic [1:0] i_ptr_sel,
    input wire logic [PTR_W-1:0] i_ptr_value,
    output logic o_instr_ready,
    output logic [PTR_W-1:0] o_file_select_pointer0,
    output logic [PTR_W-1:0] o_file_select_pointer1,
    output logic [PTR_W-1:0] o_stack_frame_pointer,
    output logic o_ext_enabled,
    output logic o_addr_valid,
    output logic [PTR_W-1:0] o_eff_addr,
    output logic o_indexed,
    output logic o_dest_to_file,
    output logic o_flags_hold,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    output logic o_nop_cycle
);
    import iod_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Offset adder and bank concatenation are built for 12-bit pointers
    if (PTR_W != IOD_PTR_W) begin : g_bad_ptr_w
        $error("iod_decode: PTR_W must equal the 12-bit pointer width");
    end
    if (PC_W < 2) begin : g_bad_pc_w
        $error("iod_decode: PC_W too small");
    end

    // ------------------------------------------------------------
    // Opcode classification
    // ------------------------------------------------------------
    // Byte- and bit-oriented groups are the ones that carry the access bit
    function automatic logic has_access_bit(input logic [IOD_OP_W-1:0] op);
        logic [3:0] hi;
        hi = op[15:12];
        if (hi == 4'h0) begin
            has_access_bit = (op[11:9] != 3'h0) && !op[11]; // Multiply, decrement
        end else begin
            has_access_bit = (hi >= 4'h1) && (hi <= 4'hb);
        end
    endfunction : has_access_bit

    // Only the plain byte groups carry a destination bit
    function automatic logic has_dest_bit(input logic [IOD_OP_W-1:0] op);
        logic [3:0] hi;
        hi = op[15:12];
        has_dest_bit = ((hi == 4'h0) && (op[11:10] == 2'h1)) || ((hi >= 4'h1) && (hi <= 4'h5));
    endfunction : has_dest_bit

    // Modulo pointer-width subtraction of a 6-bit literal
    function automatic logic [IOD_PTR_W-1:0] ptr_sub(input logic [IOD_PTR_W-1:0] ptr,
                                                     input logic [IOD_LIT_W-1:0] lit);
        ptr_sub = ptr - {{(IOD_PTR_W - IOD_LIT_W){1'b0}}, lit};
    endfunction : ptr_sub

    // ------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------
    iod_state_t state_ff;
    iod_state_t nxt_state;
    logic ext_en_ff;
    logic [PTR_W-1:0] ptr_ff [0:2];
    logic [PTR_W-1:0] nxt_ptr [0:2];
    logic addr_valid_ff;
    logic [PTR_W-1:0] eff_addr_ff;
    logic indexed_ff;
    logic dest_ff;
    logic flags_hold_ff;
    logic pc_load_ff;
    logic [PC_W-1:0] pc_value_ff;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire accept = i_instr_valid && (state_ff == IOD_EXEC);
    wire is_sub_family = (i_opcode[15:8] == IOD_SUB_FAMILY);
    wire [1:0] sub_sel = i_opcode[IOD_SEL_LSB+1:IOD_SEL_LSB];
    wire [IOD_LIT_W-1:0] sub_lit = i_opcode[IOD_LIT_W-1:0];
    wire do_sub_ptr = accept && is_sub_family && (sub_sel != IOD_SEL_FRAME);
    wire do_sub_ret = accept && is_sub_family && (sub_sel == IOD_SEL_FRAME);
    wire do_file_op = accept && has_access_bit(i_opcode);
    wire [PTR_W-1:0] gen_addr;
    wire gen_indexed;

    // Extension state alone selects offset addressing; no other mode bit
    iod_addr_gen i_iod_addr_gen (
        .i_ext_enable(ext_en_ff),
        .i_access_sel(i_opcode[IOD_ACCESS_BIT]),
        .i_file(i_opcode[IOD_FILE_W-1:0]),
        .i_bank_select(i_bank_select),
        .i_frame_ptr(ptr_ff[2]),
        .o_addr(gen_addr),
        .o_indexed(gen_indexed)
    );

    // Pointer next values; the executing subtract beats a core load
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            nxt_ptr[i] = ptr_ff[i];
            if (i_ptr_load && (i_ptr_sel == 2'(i))) begin
                nxt_ptr[i] = i_ptr_value;
            end
        end
        if (do_sub_ptr) begin
            nxt_ptr[sub_sel] = ptr_sub(ptr_ff[sub_sel], sub_lit);
        end else if (do_sub_ret) begin
            nxt_ptr[2] = ptr_sub(ptr_ff[2], sub_lit);
        end
    end

    // Return occupies one further cycle doing nothing
    always_comb begin
        case (state_ff)
            IOD_EXEC: nxt_state = do_sub_ret ? IOD_RET_NOP : IOD_EXEC;
            IOD_RET_NOP: nxt_state = IOD_EXEC;
            default: nxt_state = IOD_EXEC;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Config bit caught while reset is held, so it is fixed while running
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ext_en_ff <= i_ext_enable_cfg;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_ff <= IOD_EXEC;
            for (int i = 0; i < 3; i++) begin
                ptr_ff[i] <= IOD_PTR_RESET;
            end
        end else begin
            state_ff <= nxt_state;
            for (int i = 0; i < 3; i++) begin
                ptr_ff[i] <= nxt_ptr[i];
            end
        end
    end

    // Result strobes: one cycle after the instruction is taken
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            addr_valid_ff <= 1'b0;
            eff_addr_ff <= IOD_PTR_RESET;
            indexed_ff <= 1'b0;
            dest_ff <= 1'b0;
            flags_hold_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            pc_value_ff <= '0;
        end else begin
            addr_valid_ff <= do_file_op;
            eff_addr_ff <= do_file_op ? gen_addr : eff_addr_ff;
            indexed_ff <= do_file_op && gen_indexed;
            dest_ff <= do_file_op && has_dest_bit(i_opcode) && i_opcode[IOD_DEST_BIT];
            flags_hold_ff <= do_sub_ptr || do_sub_ret || (state_ff == IOD_RET_NOP);
            pc_load_ff <= do_sub_ret;
            pc_value_ff <= do_sub_ret ? i_top_of_return_stack : pc_value_ff;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Ready drops for the no-operation cycle only
    assign o_instr_ready = (state_ff == IOD_EXEC);
    assign o_file_select_pointer0 = ptr_ff[0];
    assign o_file_select_pointer1 = ptr_ff[1];
    assign o_stack_frame_pointer = ptr_ff[2];
    assign o_ext_enabled = ext_en_ff;
    assign o_addr_valid = addr_valid_ff;
    assign o_eff_addr = eff_addr_ff;
    assign o_indexed = indexed_ff;
    assign o_dest_to_file = dest_ff;
    assign o_flags_hold = flags_hold_ff;
    assign o_pc_load = pc_load_ff;
    assign o_pc_value = pc_value_ff;
    assign o_nop_cycle = (state_ff == IOD_RET_NOP);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_sub_ptr_value: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        do_sub_ptr |=> (ptr_ff[$past(sub_sel)] == ptr_sub($past(ptr_ff[sub_sel]), $past(sub_lit))))
        else $error("pointer subtract result wrong");

    a_sub_one_cycle: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        do_sub_ptr |=> (o_instr_ready && !o_pc_load && o_flags_hold))
        else $error("pointer subtract not single cycle");

    a_ret_pc_load: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        do_sub_ret |=> (o_pc_load && (o_pc_value == $past(i_top_of_return_stack))
                        && (o_stack_frame_pointer == $past(ptr_sub(ptr_ff[2], sub_lit)))))
        else $error("return did not load pc or frame pointer");

    a_ret_nop_cycle: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        do_sub_ret |=> (o_nop_cycle && !o_instr_ready) ##1 (o_instr_ready && !o_addr_valid
                        && o_flags_hold && !o_pc_load))
        else $error("return second cycle not a no-operation");

    a_lit_access_bank: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (do_file_op && !ext_en_ff) |=> (!o_indexed && (o_eff_addr == ($past(i_opcode[8])
            ? {$past(i_bank_select), $past(i_opcode[7:0])} : {((($past(i_opcode[7:0]))
            < IOD_ACCESS_SPLIT) ? IOD_ACCESS_LOW_BANK : IOD_ACCESS_HIGH_BANK),
            $past(i_opcode[7:0])}))))
        else $error("literal address wrong with extension off");

    a_offset_addr: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (do_file_op && ext_en_ff && !i_opcode[8] && (i_opcode[7:0] <= IOD_OFFSET_MAX))
        |=> (o_indexed && (o_eff_addr == $past(ptr_ff[2]) + {4'h0, $past(i_opcode[7:0])})))
        else $error("offset address not frame pointer plus operand");

    a_above_limit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (do_file_op && (i_opcode[7:0] > IOD_OFFSET_MAX)) |=> !o_indexed)
        else $error("operand above limit was indexed");

    a_dest_bit: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        (do_file_op && (i_opcode[15:12] == 4'h2)) |=> (o_dest_to_file == $past(i_opcode[9])))
        else $error("destination bit meaning changed");

    a_config_stable: assert property (@(posedge i_clock) disable iff (i_sys_rst)
        ##1 $stable(o_ext_enabled))
        else $error("extension enable changed while running");
endmodule : iod_decode

// ==== bench/iod_decode_test.sv ====
`timescale 1ns/1ps
module iod_decode_test;
    import iod_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, observed outputs and counters
    // ------------------------------------------------------------
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_ext_enable_cfg = 1'b1;
    logic i_instr_valid = 1'b0;
    logic [15:0] i_opcode = 16'h0000;
    logic [3:0] i_bank_select = 4'h0;
    logic [20:0] i_top_of_return_stack = 21'h000000;
    logic i_ptr_load = 1'b0;
    logic [1:0] i_ptr_sel = 2'h0;
    logic [11:0] i_ptr_value = 12'h000;
    logic o_instr_ready, o_ext_enabled, o_addr_valid, o_indexed, o_dest_to_file;
    logic o_flags_hold, o_pc_load, o_nop_cycle;
    logic [11:0] o_file_select_pointer0, o_file_select_pointer1, o_stack_frame_pointer;
    logic [11:0] o_eff_addr;
    logic [20:0] o_pc_value;
    int fails = 0;
    int comparisons = 0;

    // Half period of the 200 MHz clock
    always #2.5 i_clock = ~i_clock;

    iod_decode i_iod_decode (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_ext_enable_cfg(i_ext_enable_cfg),
        .i_instr_valid(i_instr_valid), .i_opcode(i_opcode), .i_bank_select(i_bank_select),
        .i_top_of_return_stack(i_top_of_return_stack), .i_ptr_load(i_ptr_load),
        .i_ptr_sel(i_ptr_sel), .i_ptr_value(i_ptr_value), .o_instr_ready(o_instr_ready),
        .o_file_select_pointer0(o_file_select_pointer0),
        .o_file_select_pointer1(o_file_select_pointer1),
        .o_stack_frame_pointer(o_stack_frame_pointer), .o_ext_enabled(o_ext_enabled),
        .o_addr_valid(o_addr_valid), .o_eff_addr(o_eff_addr), .o_indexed(o_indexed),
        .o_dest_to_file(o_dest_to_file), .o_flags_hold(o_flags_hold),
        .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_nop_cycle(o_nop_cycle)
    );

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    // Four-state compare so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic end_of_test;
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // Config flips at release so a late sample would show up
    task automatic reset_dut(input logic cfg);
        @(posedge i_clock) i_sys_rst <= 1'b1;
        i_ext_enable_cfg <= cfg;
        repeat (6) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        i_ext_enable_cfg <= ~cfg;
        #1;
        chk(o_ext_enabled, cfg, "config capture");
        chk(o_instr_ready, 1'b1, "ready after reset");
        chk(o_stack_frame_pointer, 12'h000, "frame pointer reset");
    endtask : reset_dut

    task automatic load_ptr(input logic [1:0] sel, input logic [11:0] val);
        @(posedge i_clock) i_ptr_load <= 1'b1;
        i_ptr_sel <= sel;
        i_ptr_value <= val;
        @(posedge i_clock) i_ptr_load <= 1'b0;
    endtask : load_ptr

    // One-cycle request, returns in the answer cycle
    task automatic issue(input logic [15:0] op);
        @(posedge i_clock) i_instr_valid <= 1'b1;
        i_opcode <= op;
        @(posedge i_clock) i_instr_valid <= 1'b0;
        #1;
    endtask : issue

    function automatic logic [11:0] ptr_of(input logic [1:0] sel);
        return (sel == 2'd0) ? o_file_select_pointer0 :
               (sel == 2'd1) ? o_file_select_pointer1 : o_stack_frame_pointer;
    endfunction : ptr_of

    // Frame pointer is 0xff0 and bank 5 in the addressing scenarios
    function automatic logic [11:0] exp_addr(input logic ext, input logic a,
                                             input logic [7:0] f);
        if (ext && !a && f <= 8'h5f) return 12'hff0 + {4'h0, f};
        if (a) return {4'h5, f};
        return (f < 8'h60) ? {4'h0, f} : {4'hf, f};
    endfunction : exp_addr

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Each pointer, with large literals; those on pointers 0 and 2 wrap below zero
    task automatic sub_pointers;
        logic [11:0] start [3] = '{12'h010, 12'h3ff, 12'h020};
        logic [5:0] lit [3] = '{6'h3f, 6'h23, 6'h3f};
        for (int s = 0; s < 3; s++) begin
            load_ptr(2'(s), start[s]);
            issue({8'he9, 2'(s), lit[s]});
            chk(ptr_of(2'(s)), 12'(start[s] - {6'h00, lit[s]}), "pointer subtract");
            chk(o_flags_hold, 1'b1, "flags held on subtract");
            chk(o_pc_load, 1'b0, "no return on subtract");
            chk(o_instr_ready, 1'b1, "subtract takes one cycle");
        end
    endtask : sub_pointers

    // Subtract beats a core load on the same pointer; select 3 loads nothing
    task automatic ptr_clash;
        load_ptr(2'd1, 12'h100);
        @(posedge i_clock) i_ptr_load <= 1'b1;
        i_ptr_sel <= 2'd1;
        i_ptr_value <= 12'h555;
        i_instr_valid <= 1'b1;
        i_opcode <= {8'he9, 2'd1, 6'h05};
        @(posedge i_clock) i_ptr_load <= 1'b0;
        i_instr_valid <= 1'b0;
        #1;
        chk(o_file_select_pointer1, 12'h0fb, "subtract wins over load");
        load_ptr(2'd3, 12'h777);
        #1;
        chk(o_file_select_pointer0, 12'hfd1, "select 3 left pointer 0");
        chk(o_file_select_pointer1, 12'h0fb, "select 3 left pointer 1");
        chk(o_stack_frame_pointer, 12'hfe1, "select 3 left frame pointer");
    endtask : ptr_clash

    // Return with a request held through the dead cycle
    task automatic sub_return;
        logic [11:0] old0;
        load_ptr(2'd2, 12'h3ff);
        i_top_of_return_stack <= 21'h012345;
        old0 = o_file_select_pointer0;
        @(posedge i_clock) i_instr_valid <= 1'b1;
        i_opcode <= {8'he9, 2'b11, 6'h23};
        @(posedge i_clock) i_opcode <= {8'he9, 2'b00, 6'h01};
        i_top_of_return_stack <= 21'h1fffff;
        #1;
        chk(o_stack_frame_pointer, 12'h3dc, "frame subtract");
        chk(o_pc_load, 1'b1, "pc load");
        chk(o_pc_value, 21'h012345, "pc from stack top");
        chk(o_nop_cycle, 1'b1, "second cycle idle");
        chk(o_instr_ready, 1'b0, "ready low in idle cycle");
        chk(o_flags_hold, 1'b1, "flags held");
        @(posedge i_clock) i_instr_valid <= 1'b0;
        #1;
        chk(o_instr_ready, 1'b1, "ready back");
        chk(o_pc_load, 1'b0, "pc load one cycle");
        chk(o_flags_hold, 1'b1, "flags held in idle cycle");
        chk(o_pc_value, 21'h012345, "pc value holds");
        @(posedge i_clock) #1;
        chk(o_file_select_pointer0, old0, "request in idle cycle ignored");
    endtask : sub_return

    // Byte and bit operations over offset boundaries and both access values
    task automatic file_ops(input logic ext);
        logic [7:0] fs [4] = '{8'h00, 8'h5f, 8'h60, 8'hff};
        logic [15:0] op;
        logic d;
        reset_dut(ext);
        load_ptr(2'd2, 12'hff0);
        i_bank_select <= 4'h5;
        for (int a = 0; a < 2; a++) begin
            for (int i = 0; i < 4; i++) begin
                for (int g = 0; g < 2; g++) begin
                    d = (g == 0) && i[0];
                    op = (g == 1) ? {4'h8, 3'h5, 1'(a), fs[i]} : {6'h09, d, 1'(a), fs[i]};
                    issue(op);
                    chk(o_addr_valid, 1'b1, "address presented");
                    chk(o_eff_addr, exp_addr(ext, 1'(a), fs[i]), "effective address");
                    chk(o_indexed, ext && a == 0 && fs[i] <= 8'h5f, "offset mode");
                    chk(o_dest_to_file, d, "destination bit");
                end
            end
        end
    endtask : file_ops

    // Every access-bit group takes the offset path; other groups present no address
    task automatic group_sweep;
        logic [7:0] grp [14] = '{8'h02, 8'h04, 8'h06, 8'h10, 8'h28, 8'h34, 8'h44, 8'h50,
                                 8'h60, 8'h70, 8'h80, 8'h90, 8'ha0, 8'hb0};
        logic [7:0] other [6] = '{8'h00, 8'h0e, 8'hc0, 8'hd0, 8'he0, 8'hf0};
        load_ptr(2'd2, 12'h200);
        for (int i = 0; i < 14; i++) begin
            issue({grp[i], 8'h2a});
            chk(o_addr_valid, 1'b1, "group presents address");
            chk(o_indexed, 1'b1, "group uses offset");
            chk(o_eff_addr, 12'h22a, "group offset address");
        end
        for (int i = 0; i < 6; i++) begin
            issue({other[i], 8'h2a});
            chk(o_addr_valid, 1'b0, "no address outside groups");
            chk(o_indexed, 1'b0, "no offset outside groups");
        end
    endtask : group_sweep

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        reset_dut(1'b1);
        sub_pointers();
        ptr_clash();
        sub_return();
        file_ops(1'b1);
        group_sweep();
        file_ops(1'b0);
        end_of_test();
    end

    // Whole run is about 155 cycles, so this is ample
    initial begin
        repeat (3000) @(posedge i_clock);
        fails++;
        end_of_test();
    end
endmodule : iod_decode_test
